// ===== dv/tb.sv
// Self-checking testbench for the instruction execution block
`timescale 1ns/1ps
module tb;
	import exec_pkg::*;
	logic hclk;
	logic hresetn;
	logic [ADDR_W-1:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [DATA_W-1:0] hwdata;
	logic wdt_timeout_evt;
	logic sleep_evt;
	logic [DATA_W-1:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic wdt_clear;
	int fail_count = 0;
	int check_count = 0;
	int seed = 32'h4e0dfea3;
	int wdt_pulses = 0;
	int exp_pulses = 0;
	logic [31:0] exp_q[$];
	logic [31:0] adr_q[$];
	logic [31:0] e_v;
	logic [31:0] a_v;
	logic rd_phase = 1'b0;
	// Reference model of the visible state
	logic [7:0] w_e;
	logic [7:0] pch_e;
	logic [7:0] fm[FDEPTH];
	logic [PC_W-1:0] pc_e;
	logic [PC_W-1:0] stk_e;
	logic z_e;
	logic pd_e;
	logic to_e;
	opcode_t op;
	logic [6:0] fa;

	instr_exec uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .wdt_timeout_evt(wdt_timeout_evt),
		.sleep_evt(sleep_evt), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wdt_clear(wdt_clear));

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			fail_count++;
		end
	endtask : chk

	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1)
			chk("hreadyout", 32'h1, {31'h0, hreadyout});
	endtask : wait_ready

	task automatic bus(input logic [31:0] addr, input logic wr_en, input logic [31:0] data);
		@(posedge hclk);
		haddr <= addr;
		hwrite <= wr_en;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= data;
		wait_ready();
	endtask : bus

	task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
		exp_q.push_back(exp);
		adr_q.push_back(addr);
		bus(addr, 1'b0, 32'h0);
	endtask : rd

	task automatic set_file(input logic [6:0] f, input logic [7:0] v);
		bus(32'h200 + {23'h0, f, 2'b00}, 1'b1, {24'h0, v});
		fm[f] = v;
	endtask : set_file

	task automatic check_state(input logic [6:0] f);
		rd(32'(OFF_WORK), {24'h0, w_e});
		rd(32'(OFF_PC), {17'h0, pc_e});
		rd(32'(OFF_STACK), {17'h0, stk_e});
		rd(32'(OFF_STATUS), {28'h0, 1'b0, to_e, pd_e, z_e});
		rd(32'h200 + {23'h0, f, 2'b00}, {24'h0, fm[f]});
		chk("wdt_clear pulses", 32'(exp_pulses), 32'(wdt_pulses));
	endtask : check_state

	task automatic run_op(input opcode_t o, input logic d, input logic [6:0] f);
		logic [7:0] r;
		instr_t ins;
		r = 8'h00;
		ins.op = o;
		ins.dest = d;
		ins.faddr = f;
		bus(32'(OFF_INSTR), 1'b1, {21'h0, ins});
		repeat (4) @(posedge hclk);
		if (o == op_call_via_work_reg) begin
			stk_e = pc_e + 15'h1;
			pc_e = {pch_e[6:0], w_e};
		end else begin
			case (o)
				op_nop: r = 8'h01;
				op_clear_file_reg: begin
					fm[f] = 8'h00;
					z_e = 1'b1;
				end
				op_clear_work_reg: begin
					w_e = 8'h00;
					z_e = 1'b1;
				end
				op_clear_watchdog: begin
					to_e = 1'b1;
					pd_e = 1'b1;
					exp_pulses++;
				end
				default: begin
					r = (o == op_complement_file_reg) ? ~fm[f] : fm[f] - 8'h01;
					if (o != op_decrement_skip_zero)
						z_e = (r == 8'h00);
					if (d)
						fm[f] = r;
					else
						w_e = r;
				end
			endcase
			pc_e = pc_e + ((o == op_decrement_skip_zero && r == 8'h00) ? 15'h2 : 15'h1);
		end
		check_state(f);
	endtask : run_op

	always @(posedge hclk) begin
		if (wdt_clear === 1'b1)
			wdt_pulses++;
		if (rd_phase && hreadyout === 1'b1) begin
			rd_phase = 1'b0;
			e_v = exp_q.pop_front();
			a_v = adr_q.pop_front();
			chk($sformatf("read %h", a_v), e_v, hrdata);
			chk("hresp", 32'h0, {31'h0, hresp});
		end
		if (htrans[1] && hreadyout === 1'b1 && !hwrite)
			rd_phase = 1'b1;
	end

	initial begin
		repeat (30000) @(posedge hclk);
		$display("CHECK FAILED watchdog expected end seen hang");
		fail_count++;
		final_report();
	end

	initial begin
		hresetn = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = '0;
		wdt_timeout_evt = 1'b0;
		sleep_evt = 1'b0;
		w_e = 8'h00;
		pch_e = 8'h00;
		pc_e = '0;
		stk_e = '0;
		z_e = 1'b0;
		pd_e = 1'b1;
		to_e = 1'b1;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd(32'(OFF_INSTR), 32'h0);
		rd(32'(OFF_PCH), 32'h0);
		rd(32'h018, 32'h0);
		rd(32'h1000, 32'h0);
		set_file(7'h00, 8'($random(seed)));
		check_state(7'h0);
		$display("test reset done");
		pch_e = {1'b0, 7'($random(seed))};
		bus(32'(OFF_PCH), 1'b1, {24'h0, pch_e});
		rd(32'(OFF_PCH), {24'h0, pch_e});
		pc_e = 15'($random(seed));
		bus(32'(OFF_PC), 1'b1, {17'h0, pc_e});
		@(posedge hclk);
		wdt_timeout_evt <= 1'b1;
		sleep_evt <= 1'b1;
		repeat (4) @(posedge hclk);
		wdt_timeout_evt <= 1'b0;
		sleep_evt <= 1'b0;
		to_e = 1'b0;
		pd_e = 1'b0;
		check_state(7'h0);
		run_op(op_clear_watchdog, 1'b0, 7'h0);
		$display("test watchdog done");
		set_file(7'h05, 8'h01);
		run_op(op_decrement_skip_zero, 1'b1, 7'h05);
		run_op(op_decrement_skip_zero, 1'b0, 7'h05);
		run_op(op_decrement_file_reg, 1'b1, 7'h05);
		run_op(op_complement_file_reg, 1'b1, 7'h05);
		run_op(op_nop, 1'b1, 7'h05);
		set_file(7'h7f, 8'h5a);
		run_op(op_clear_file_reg, 1'b0, 7'h7f);
		run_op(op_call_via_work_reg, 1'b0, 7'h7f);
		run_op(op_clear_work_reg, 1'b0, 7'h7f);
		$display("test directed done");
		for (int i = 0; i < 40; i++) begin
			op = opcode_t'(3'($unsigned($random(seed)) % 8));
			fa = 7'($random(seed));
			w_e = 8'($random(seed));
			bus(32'(OFF_WORK), 1'b1, {24'h0, w_e});
			set_file(fa, (i % 3 == 0) ? 8'(i % 2) : 8'($random(seed)));
			run_op(op, 1'($random(seed)), fa);
		end
		$display("test random done");
		repeat (2) @(posedge hclk);
		chk("pending reads", 32'h0, 32'(exp_q.size()));
		final_report();
	end
endmodule : tb

// ===== hw/_unused_placeholder_removed.sv
// Intentionally empty design file holding no logic
`timescale 1ns/1ps

// ===== hw/exec_alu.sv
// Result and zero detection for the file register operations
`timescale 1ns/1ps
module exec_alu (
	input wire exec_pkg::opcode_t op,
	input wire logic [7:0] operand,
	output exec_pkg::alu_out_t res
);
	import exec_pkg::*;

	always_comb begin
		res.value = 8'h00;
		unique case (op)
			op_complement_file_reg: res.value = ~operand;
			op_decrement_file_reg, op_decrement_skip_zero: res.value = operand - 8'h01;
			default: res.value = 8'h00;
		endcase
		res.zero = (res.value == 8'h00);
	end
endmodule : exec_alu

// ===== hw/file_ram.sv
// File register array, one write port and two read ports
`timescale 1ns/1ps
module file_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic hclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr_a,
	output logic [WIDTH-1:0] rdata_a,
	input wire logic [AW-1:0] raddr_b,
	output logic [WIDTH-1:0] rdata_b
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata_a = mem[raddr_a];
	assign rdata_b = mem[raddr_b];
endmodule : file_ram

// ===== hw/instr_exec.sv
// Instruction execution subset with AHB-Lite register access
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module instr_exec (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [exec_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [exec_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	input wire logic wdt_timeout_evt,
	input wire logic sleep_evt,
	output logic [exec_pkg::DATA_W-1:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic wdt_clear
);
	import exec_pkg::*;

	logic [1:0] ext_sync1_ff;
	logic [1:0] ext_sync2_ff;
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [11:0] wr_addr_ff;
	logic [11:0] rd_addr_ff;
	logic [DATA_W-1:0] hrdata_ff;
	logic hreadyout_ff;
	logic wdt_clear_ff;
	logic addr_phase;
	logic addr_hit;
	exec_state_t state_ff;
	exec_state_t nxt_state;
	instr_t instr_ff;
	logic [PC_W-1:0] pc_ff;
	logic [PC_W-1:0] stack_top_ff;
	logic [7:0] work_ff;
	logic [PCH_W-1:0] pch_ff;
	logic zero_ff;
	logic timeout_flag_n_ff;
	logic powerdown_flag_n_ff;
	logic in_exec;
	logic start;
	logic skip;
	logic dest_file;
	logic fwe;
	logic exec_fwe;
	logic bus_fwe;
	logic [FADDR_W-1:0] fwaddr;
	logic [7:0] fwdata;
	logic [7:0] fdata;
	logic [7:0] bus_fdata;
	logic [DATA_W-1:0] rd_mux;
	alu_out_t alu;

	// Two-flop synchronisers for the external watchdog events
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_sync1_ff <= 2'h0;
			ext_sync2_ff <= 2'h0;
		end else begin
			ext_sync1_ff <= {sleep_evt, wdt_timeout_evt};
			ext_sync2_ff <= ext_sync1_ff;
		end
	end

	// Bus address phase capture
	assign addr_phase = hsel && hready && htrans[1];
	assign addr_hit = (haddr[ADDR_W-1:12] == '0) && (haddr[1:0] == 2'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 12'h000;
		end else begin
			wr_pend_ff <= addr_phase && hwrite && addr_hit;
			if (addr_phase && hwrite) begin
				wr_addr_ff <= haddr[11:0];
			end
		end
	end

	// Reads insert one wait state so earlier writes are visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend_ff <= 1'b0;
			rd_addr_ff <= 12'h000;
			hreadyout_ff <= 1'b1;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			rd_pend_ff <= addr_phase && !hwrite;
			hreadyout_ff <= !(addr_phase && !hwrite);
			if (addr_phase && !hwrite) begin
				rd_addr_ff <= addr_hit ? haddr[11:0] : 12'hfff;
			end
			if (rd_pend_ff) begin
				hrdata_ff <= rd_mux;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (rd_addr_ff[11:9] == FILE_REGION) begin
			rd_mux[7:0] = bus_fdata;
		end else begin
			unique case (rd_addr_ff)
				OFF_WORK: rd_mux[7:0] = work_ff;
				OFF_PC: rd_mux[PC_W-1:0] = pc_ff;
				OFF_PCH: rd_mux[PCH_W-1:0] = pch_ff;
				OFF_STACK: rd_mux[PC_W-1:0] = stack_top_ff;
				OFF_STATUS: begin
					rd_mux[ST_ZERO_BIT] = zero_ff;
					rd_mux[ST_PD_BIT] = powerdown_flag_n_ff;
					rd_mux[ST_TO_BIT] = timeout_flag_n_ff;
					rd_mux[ST_BUSY_BIT] = (state_ff != st_idle);
				end
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0;

	// Instruction start, ignored while busy
	assign start = wr_pend_ff && (wr_addr_ff == OFF_INSTR) && (state_ff == st_idle);
	assign in_exec = (state_ff == st_exec);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_ff <= '0;
		end else if (start) begin
			instr_ff <= instr_t'(hwdata[INSTR_W-1:0]);
		end
	end

	assign skip = (instr_ff.op == op_decrement_skip_zero) && alu.zero;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			st_idle: nxt_state = start ? st_exec : st_idle;
			st_exec: nxt_state = ((instr_ff.op == op_call_via_work_reg) || skip) ? st_second : st_idle;
			st_second: nxt_state = st_idle;
			default: nxt_state = st_idle;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= st_idle;
		end else begin
			state_ff <= nxt_state;
		end
	end

	exec_alu u_alu (
		.op(instr_ff.op),
		.operand(fdata),
		.res(alu)
	);

	assign dest_file = instr_ff.dest && (instr_ff.op inside {op_complement_file_reg,
		op_decrement_file_reg, op_decrement_skip_zero});
	assign exec_fwe = in_exec && (dest_file || (instr_ff.op == op_clear_file_reg));
	assign bus_fwe = wr_pend_ff && (wr_addr_ff[11:9] == FILE_REGION) && !exec_fwe;
	assign fwe = exec_fwe || bus_fwe;
	assign fwaddr = exec_fwe ? instr_ff.faddr : wr_addr_ff[8:2];
	assign fwdata = exec_fwe ? alu.value : hwdata[7:0];

	file_ram #(
		.WIDTH(8),
		.DEPTH(FDEPTH),
		.AW(FADDR_W)
	) u_ram (
		.hclk(hclk),
		.we(fwe),
		.waddr(fwaddr),
		.wdata(fwdata),
		.raddr_a(instr_ff.faddr),
		.rdata_a(fdata),
		.raddr_b(rd_addr_ff[8:2]),
		.rdata_b(bus_fdata)
	);

	// Program counter and return stack top
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_ff <= PC_RST;
			stack_top_ff <= PC_RST;
		end else if (in_exec) begin
			if (instr_ff.op == op_call_via_work_reg) begin
				stack_top_ff <= pc_ff + 15'h0001;
				pc_ff <= {pch_ff, work_ff};
			end else if (skip) begin
				pc_ff <= pc_ff + 15'h0002;
			end else begin
				pc_ff <= pc_ff + 15'h0001;
			end
		end else if (wr_pend_ff && wr_addr_ff == OFF_PC) begin
			pc_ff <= hwdata[PC_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pch_ff <= PCH_RST;
		end else if (wr_pend_ff && wr_addr_ff == OFF_PCH) begin
			pch_ff <= hwdata[PCH_W-1:0];
		end
	end

	// Work register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			work_ff <= WORK_RST;
		end else if (in_exec && instr_ff.op == op_clear_work_reg) begin
			work_ff <= 8'h00;
		end else if (in_exec && !instr_ff.dest && instr_ff.op inside {op_complement_file_reg,
			op_decrement_file_reg, op_decrement_skip_zero}) begin
			work_ff <= alu.value;
		end else if (wr_pend_ff && wr_addr_ff == OFF_WORK) begin
			work_ff <= hwdata[7:0];
		end
	end

	// Zero flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zero_ff <= ZERO_RST;
		end else if (in_exec) begin
			unique case (instr_ff.op)
				op_clear_file_reg, op_clear_work_reg: zero_ff <= 1'b1;
				op_complement_file_reg, op_decrement_file_reg: zero_ff <= alu.zero;
				default: zero_ff <= zero_ff;
			endcase
		end
	end

	// Watchdog status flags, clear instruction wins over events
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timeout_flag_n_ff <= FLAG_N_RST;
			powerdown_flag_n_ff <= FLAG_N_RST;
		end else if (in_exec && instr_ff.op == op_clear_watchdog) begin
			timeout_flag_n_ff <= 1'b1;
			powerdown_flag_n_ff <= 1'b1;
		end else begin
			if (ext_sync2_ff[0]) begin
				timeout_flag_n_ff <= 1'b0;
			end
			if (ext_sync2_ff[1]) begin
				powerdown_flag_n_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_clear_ff <= 1'b0;
		end else begin
			wdt_clear_ff <= in_exec && (instr_ff.op == op_clear_watchdog);
		end
	end

	assign wdt_clear = wdt_clear_ff;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_call_push_ret: assert property (in_exec && instr_ff.op == op_call_via_work_reg |=>
		stack_top_ff == $past(pc_ff) + 15'h0001) else $error("call return address wrong");
	a_call_pc_load: assert property (in_exec && instr_ff.op == op_call_via_work_reg |=>
		pc_ff == {$past(pch_ff), $past(work_ff)}) else $error("call target wrong");
	a_call_two_cycles: assert property (in_exec && instr_ff.op == op_call_via_work_reg |=>
		state_ff == st_second ##1 state_ff == st_idle && $stable(zero_ff)) else $error("call timing or flag");
	a_clear_file_reg_write: assert property (in_exec && instr_ff.op == op_clear_file_reg |->
		fwe && fwaddr == instr_ff.faddr && fwdata == 8'h00 ##1 zero_ff) else $error("clear file wrong");
	a_clear_work_reg_result: assert property (in_exec && instr_ff.op == op_clear_work_reg |=>
		work_ff == 8'h00 && zero_ff) else $error("clear work wrong");
	a_wdt_pulse: assert property (in_exec && instr_ff.op == op_clear_watchdog |=>
		wdt_clear ##1 !wdt_clear) else $error("watchdog clear pulse wrong");
	a_wdt_flags_set: assert property (in_exec && instr_ff.op == op_clear_watchdog |=>
		timeout_flag_n_ff && powerdown_flag_n_ff && $stable(zero_ff)) else $error("watchdog flags wrong");
	a_complement_file_reg_to_work: assert property (in_exec && instr_ff.op == op_complement_file_reg && !instr_ff.dest |=>
		work_ff == ~$past(fdata) && zero_ff == ($past(fdata) == 8'hff)) else $error("complement wrong");
	a_dest_file_write: assert property (in_exec && dest_file |->
		fwe && fwaddr == instr_ff.faddr && fwdata == alu.value) else $error("file destination missed");
	a_decrement_file_reg_zero: assert property (in_exec && instr_ff.op == op_decrement_file_reg |=>
		zero_ff == ($past(fdata) == 8'h01)) else $error("decrement zero flag wrong");
	a_skip_taken: assert property (in_exec && instr_ff.op == op_decrement_skip_zero && fdata == 8'h01 |=>
		state_ff == st_second && pc_ff == $past(pc_ff) + 15'h0002) else $error("skip not taken");
	a_skip_not_taken: assert property (in_exec && instr_ff.op == op_decrement_skip_zero && fdata != 8'h01 |=>
		state_ff == st_idle && pc_ff == $past(pc_ff) + 15'h0001) else $error("spurious skip");
	a_dec_wrap: assert property (in_exec && instr_ff.op == op_decrement_file_reg && fdata == 8'h00 |->
		alu.value == 8'hff && !alu.zero) else $error("decrement wrap wrong");
	a_skip_flags_kept: assert property (in_exec && instr_ff.op == op_decrement_skip_zero |=>
		$stable(zero_ff)) else $error("skip changed zero flag");

	c_call: cover property (in_exec && instr_ff.op == op_call_via_work_reg);
	c_skip: cover property (in_exec && skip);
	c_wdt: cover property (in_exec && instr_ff.op == op_clear_watchdog);
	c_read_status: cover property (rd_pend_ff && rd_addr_ff == OFF_STATUS);
endmodule : instr_exec

// ===== include/exec_pkg.sv
// Shared constants, types and register map of the instruction execution block
package exec_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int PC_W = 15;
	localparam int PCH_W = 7;
	localparam int FADDR_W = 7;
	localparam int FDEPTH = 128;

	// Register byte offsets
	localparam logic [11:0] OFF_INSTR = 12'h000;
	localparam logic [11:0] OFF_WORK = 12'h004;
	localparam logic [11:0] OFF_PC = 12'h008;
	localparam logic [11:0] OFF_PCH = 12'h00c;
	localparam logic [11:0] OFF_STACK = 12'h010;
	localparam logic [11:0] OFF_STATUS = 12'h014;
	localparam logic [2:0] FILE_REGION = 3'h1;

	// Status bit positions
	localparam int ST_ZERO_BIT = 0;
	localparam int ST_PD_BIT = 1;
	localparam int ST_TO_BIT = 2;
	localparam int ST_BUSY_BIT = 3;

	// Reset values
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [PCH_W-1:0] PCH_RST = 7'h00;
	localparam logic ZERO_RST = 1'b0;
	localparam logic FLAG_N_RST = 1'b1;

	typedef enum logic [2:0] {
		op_nop = 3'h0,
		op_call_via_work_reg = 3'h1,
		op_clear_file_reg = 3'h2,
		op_clear_work_reg = 3'h3,
		op_clear_watchdog = 3'h4,
		op_complement_file_reg = 3'h5,
		op_decrement_file_reg = 3'h6,
		op_decrement_skip_zero = 3'h7
	} opcode_t;

	// Instruction word, low bits of the write to the instruction register
	typedef struct packed {
		logic [FADDR_W-1:0] faddr;
		logic dest;
		opcode_t op;
	} instr_t;

	localparam int INSTR_W = $bits(instr_t);

	typedef struct packed {
		logic [7:0] value;
		logic zero;
	} alu_out_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_exec = 2'b01,
		st_second = 2'b11
	} exec_state_t;
endpackage : exec_pkg
